/* core/cmp_pkg.sv */
// package of constants and types for the message-object page control block
package cmp_pkg;
    // ==========================================
    // register addresses
    localparam logic [7:0] CMP_ADDR_PAGE = 8'hb1;
    localparam logic [7:0] CMP_ADDR_STATUS = 8'hb2;
    localparam logic [7:0] CMP_ADDR_CTRL = 8'hb3;
    // ==========================================
    // field positions
    localparam int CMP_PAGE_SEL_HI = 5;
    localparam int CMP_PAGE_SEL_LO = 4;
    localparam int CMP_PAGE_HOLD_BIT = 3;
    localparam int CMP_PAGE_IDX_HI = 2;
    localparam int CMP_CTRL_ROLE_HI = 7;
    localparam int CMP_CTRL_ROLE_LO = 6;
    localparam int CMP_CTRL_REPLY_BIT = 5;
    localparam int CMP_CTRL_EXT_BIT = 4;
    localparam int CMP_CTRL_LEN_HI = 3;
    localparam int CMP_ST_LEN_BIT = 7;
    localparam int CMP_ST_TX_BIT = 6;
    localparam int CMP_ST_RX_BIT = 5;
    localparam int CMP_ST_BIT_BIT = 4;
    localparam int CMP_ST_STUFF_BIT = 3;
    localparam int CMP_ST_CRC_BIT = 2;
    localparam int CMP_ST_FORM_BIT = 1;
    localparam int CMP_ST_ACK_BIT = 0;
    // ==========================================
    // counts and reset values
    localparam int CMP_NUM_OBJ = 4;
    localparam logic [7:0] CMP_PAGE_RESET = 8'h00;
    localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_STATUS_RESET = 8'h00;
    localparam logic [2:0] CMP_IDX_STEP = 3'h1;
    // ==========================================
    // types
    typedef enum logic [1:0] {
        CMP_ROLE_OFF = 2'b00,
        CMP_ROLE_TX = 2'b01,
        CMP_ROLE_RX = 2'b10,
        CMP_ROLE_RXBUF = 2'b11
    } cmp_role_t;
    typedef struct packed {
        logic [1:0] object_select;
        logic index_hold_n;
        logic [2:0] byte_index;
    } cmp_page_t;
    // per-object bus-side events from the protocol engine
    typedef struct packed {
        logic length_mismatch;
        logic rx_done;
        logic bit_error;
        logic stuff_error;
        logic crc_error;
        logic form_error;
        logic ack_error;
    } cmp_event_t;
endpackage

/* core/cmp_page_ctrl.sv */
// message-object page, control and status register window with object arbitration
`timescale 1ns/1ps
module cmp_page_ctrl
    import cmp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic data_access,
    input wire logic tx_ready,
    input wire logic tx_sent,
    input wire logic tx_bit_mismatch,
    input wire logic tx_in_arb_or_ack,
    input wire logic [CMP_NUM_OBJ-1:0] rx_hit,
    input wire cmp_event_t rx_event,
    output logic [1:0] cur_object,
    output logic [2:0] cur_byte_index,
    output logic cur_ext_id,
    output logic [CMP_NUM_OBJ-1:0] obj_enable,
    output logic tx_busy,
    output logic [1:0] tx_object
);
    // ==========================================
    // state
    cmp_page_t page_reg, page_next;
    logic [7:0] ctrl_reg [CMP_NUM_OBJ];
    logic [7:0] ctrl_next [CMP_NUM_OBJ];
    logic [7:0] stat_reg [CMP_NUM_OBJ];
    logic [7:0] stat_next [CMP_NUM_OBJ];
    logic [CMP_NUM_OBJ-1:0] en_reg, en_next;
    logic tx_busy_reg, tx_busy_next;
    logic [1:0] tx_obj_reg, tx_obj_next;
    logic [7:0] rdata_reg, rdata_next;
    logic tx_found;
    logic [1:0] tx_pick;
    logic rx_found;
    logic [1:0] rx_pick;
    logic [CMP_NUM_OBJ-1:0] tx_cand;
    logic [CMP_NUM_OBJ-1:0] rx_cand;
    logic [7:0] ev_bits;

    // ==========================================
    // lowest-number pickers
    always_comb begin
        tx_found = 1'b0;
        tx_pick = 2'h0;
        rx_found = 1'b0;
        rx_pick = 2'h0;
        tx_cand = '0;
        rx_cand = '0;
        for (int i = CMP_NUM_OBJ - 1; i >= 0; i--) begin
            tx_cand[i] = en_reg[i] &&
                ctrl_reg[i][CMP_CTRL_ROLE_HI:CMP_CTRL_ROLE_LO] == CMP_ROLE_TX;
            rx_cand[i] = rx_hit[i] && en_reg[i] && ctrl_reg[i][CMP_CTRL_ROLE_HI];
            if (tx_cand[i]) begin
                tx_found = 1'b1;
                tx_pick = 2'(i);
            end
            if (rx_cand[i]) begin
                rx_found = 1'b1;
                rx_pick = 2'(i);
            end
        end
    end

    // ==========================================
    // next-state
    always_comb begin
        page_next = page_reg;
        en_next = en_reg;
        tx_busy_next = tx_busy_reg;
        tx_obj_next = tx_obj_reg;
        rdata_next = rdata_reg;
        for (int i = 0; i < CMP_NUM_OBJ; i++) begin
            ctrl_next[i] = ctrl_reg[i];
            stat_next[i] = stat_reg[i];
        end
        ev_bits = 8'h00;
        ev_bits[CMP_ST_LEN_BIT] = rx_event.length_mismatch;
        ev_bits[CMP_ST_RX_BIT] = rx_event.rx_done;
        ev_bits[CMP_ST_STUFF_BIT] = rx_event.stuff_error;
        ev_bits[CMP_ST_CRC_BIT] = rx_event.crc_error;
        ev_bits[CMP_ST_FORM_BIT] = rx_event.form_error;
        ev_bits[CMP_ST_ACK_BIT] = rx_event.ack_error;
        if (sfr_rd) begin
            unique case (sfr_addr)
                CMP_ADDR_PAGE: rdata_next = {2'b00, page_reg};
                CMP_ADDR_STATUS: rdata_next = stat_reg[page_reg.object_select];
                CMP_ADDR_CTRL: rdata_next = ctrl_reg[page_reg.object_select];
                default: rdata_next = 8'h00;
            endcase
        end
        if (sfr_wr) begin
            unique case (sfr_addr)
                CMP_ADDR_PAGE: begin
                    page_next.object_select =
                        sfr_wdata[CMP_PAGE_SEL_HI:CMP_PAGE_SEL_LO];
                    page_next.index_hold_n = sfr_wdata[CMP_PAGE_HOLD_BIT];
                    page_next.byte_index = sfr_wdata[CMP_PAGE_IDX_HI:0];
                end
                CMP_ADDR_STATUS: stat_next[page_reg.object_select] = sfr_wdata;
                CMP_ADDR_CTRL: begin
                    ctrl_next[page_reg.object_select] = sfr_wdata;
                    // enable follows the role field only on this write
                    en_next[page_reg.object_select] =
                        sfr_wdata[CMP_CTRL_ROLE_HI:CMP_CTRL_ROLE_LO] != CMP_ROLE_OFF;
                end
                default: ;
            endcase
        end
        if (data_access && !page_reg.index_hold_n) begin
            page_next.byte_index = page_reg.byte_index + CMP_IDX_STEP;
        end
        // transmission arbitration
        if (!tx_busy_reg && tx_ready && tx_found) begin
            tx_busy_next = 1'b1;
            tx_obj_next = tx_pick;
        end
        if (tx_busy_reg) begin
            if (tx_bit_mismatch && !tx_in_arb_or_ack) begin
                stat_next[tx_obj_reg][CMP_ST_BIT_BIT] = 1'b1;
            end
            if (tx_sent) begin
                tx_busy_next = 1'b0;
                stat_next[tx_obj_reg][CMP_ST_TX_BIT] = 1'b1;
                en_next[tx_obj_reg] = 1'b0;
                ctrl_next[tx_obj_reg][CMP_CTRL_ROLE_HI:CMP_CTRL_ROLE_LO] = CMP_ROLE_OFF;
            end
        end
        // set wins over a software clear in the same cycle
        if (rx_found) begin
            stat_next[rx_pick] = stat_next[rx_pick] | ev_bits;
            if (rx_event.rx_done && ctrl_reg[rx_pick][CMP_CTRL_ROLE_LO] == 1'b0) begin
                en_next[rx_pick] = 1'b0;
            end
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            page_reg <= cmp_page_t'(CMP_PAGE_RESET[5:0]);
            en_reg <= '0;
            tx_busy_reg <= 1'b0;
            tx_obj_reg <= 2'h0;
            rdata_reg <= 8'h00;
            for (int i = 0; i < CMP_NUM_OBJ; i++) begin
                ctrl_reg[i] <= CMP_CTRL_RESET;
                stat_reg[i] <= CMP_STATUS_RESET;
            end
        end else begin
            page_reg <= page_next;
            en_reg <= en_next;
            tx_busy_reg <= tx_busy_next;
            tx_obj_reg <= tx_obj_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < CMP_NUM_OBJ; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
                stat_reg[i] <= stat_next[i];
            end
        end
    end

    // outputs registered; page fields are flop outputs already
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cur_ext_id <= 1'b0;
        end else begin
            cur_ext_id <= ctrl_next[page_next.object_select][CMP_CTRL_EXT_BIT];
        end
    end
    assign sfr_rdata = rdata_reg;
    assign cur_object = page_reg.object_select;
    assign cur_byte_index = page_reg.byte_index;
    assign obj_enable = en_reg;
    assign tx_busy = tx_busy_reg;
    assign tx_object = tx_obj_reg;

    // ==========================================
    // assertions
    a_index_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
        data_access && !page_reg.index_hold_n && !(sfr_wr && sfr_addr == CMP_ADDR_PAGE)
        |=> page_reg.byte_index == $past(page_reg.byte_index) + CMP_IDX_STEP)
        else $error("byte index did not advance");
    a_index_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        data_access && page_reg.index_hold_n && !(sfr_wr && sfr_addr == CMP_ADDR_PAGE)
        |=> $stable(page_reg.byte_index))
        else $error("byte index moved while held");
    a_select_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_wr && sfr_addr == CMP_ADDR_PAGE
        |=> cur_object == $past(sfr_wdata[CMP_PAGE_SEL_HI:CMP_PAGE_SEL_LO]))
        else $error("object select not taken");
    a_page_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == CMP_ADDR_PAGE |=> sfr_rdata[7:6] == 2'b00)
        else $error("reserved page bits not zero");
    a_enable_role: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_wr && sfr_addr == CMP_ADDR_CTRL
        && sfr_wdata[CMP_CTRL_ROLE_HI:CMP_CTRL_ROLE_LO] == CMP_ROLE_OFF
        |=> !obj_enable[$past(cur_object)])
        else $error("disable role left object enabled");
    // every bit of the enable vector is watched, not only the lowest
    a_enable_only_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(sfr_wr && sfr_addr == CMP_ADDR_CTRL) |=> (obj_enable & ~$past(obj_enable)) == '0)
        else $error("enable rose without a role write");
    a_ext_format: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_wr && sfr_addr == CMP_ADDR_CTRL
        |=> cur_ext_id == $past(sfr_wdata[CMP_CTRL_EXT_BIT]))
        else $error("identifier format not taken");
    a_tx_pick_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        tx_cand != 4'h0
        |-> tx_found && tx_cand[tx_pick] && (tx_cand & ((4'h1 << tx_pick) - 4'h1)) == 4'h0)
        else $error("transmit pick not the lowest candidate");
    a_rx_pick_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_cand != 4'h0
        |-> rx_found && rx_cand[rx_pick] && (rx_cand & ((4'h1 << rx_pick) - 4'h1)) == 4'h0)
        else $error("receive pick not the lowest hit");
    sequence s_tx_launch;
        !tx_busy && tx_ready && tx_found;
    endsequence
    a_tx_lowest: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_tx_launch |=> tx_busy && tx_object == $past(tx_pick))
        else $error("transmit arbitration wrong");
    a_tx_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        tx_busy && tx_sent |=> stat_reg[$past(tx_object)][CMP_ST_TX_BIT] && !tx_busy)
        else $error("tx done flag not set");
    a_rx_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_found && rx_event.rx_done |=> stat_reg[$past(rx_pick)][CMP_ST_RX_BIT])
        else $error("rx done flag not set");
    a_bit_error: assert property (@(posedge sys_clk) disable iff (!rstn)
        !tx_busy && !(sfr_wr && sfr_addr == CMP_ADDR_STATUS)
        |=> stat_reg[$past(tx_object)][CMP_ST_BIT_BIT]
            == $past(stat_reg[tx_object][CMP_ST_BIT_BIT]))
        else $error("bit error set outside transmission");
    a_form_error: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_found && rx_event.form_error |=> stat_reg[$past(rx_pick)][CMP_ST_FORM_BIT])
        else $error("form error flag not set");
endmodule

/* testbench/cmp_engine_model.sv */
// protocol engine stand-in: frame start permission and frame completion
`timescale 1ns/1ps
module cmp_engine_model(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic tx_busy,
    input wire logic [3:0] dly,
    output logic tx_ready,
    output logic tx_sent
);
    logic [3:0] cnt_reg;
    assign tx_ready = go & ~tx_busy;
    // ====================
    // each owned frame ends (tx_sent rises) dly+1 cycles after it starts
    always @(posedge sys_clk) begin
        if (!rstn || !tx_busy || tx_sent) begin
            cnt_reg <= 4'h0;
            tx_sent <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            tx_sent <= (cnt_reg == dly);
        end
    end
endmodule

/* testbench/tb.sv */
// self-checking bench for the message-object page control block
`timescale 1ns/1ps
module tb;
    import cmp_pkg::*;
    logic sys_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, data_access = 0, go = 0;
    logic tx_bit_mismatch = 0, tx_in_arb_or_ack = 0, tx_ready, tx_sent, cur_ext_id, tx_busy;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v;
    logic [3:0] rx_hit = 4'h0, obj_enable, dly = 4'h3;
    logic [1:0] cur_object, tx_object;
    logic [2:0] cur_byte_index;
    logic [6:0] e1, e2;
    logic p1 = 0, p2 = 0;
    logic [7:0] exp_q[$];
    cmp_event_t rx_event = '0;
    int n_errors = 0, n_tests = 0, cycles = 0;
    cmp_page_ctrl u_dut(.sys_clk(sys_clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .data_access(data_access), .tx_ready(tx_ready), .tx_sent(tx_sent),
        .tx_bit_mismatch(tx_bit_mismatch), .tx_in_arb_or_ack(tx_in_arb_or_ack),
        .rx_hit(rx_hit), .rx_event(rx_event), .cur_object(cur_object),
        .cur_byte_index(cur_byte_index), .cur_ext_id(cur_ext_id), .obj_enable(obj_enable),
        .tx_busy(tx_busy), .tx_object(tx_object));
    cmp_engine_model u_eng(.sys_clk(sys_clk), .rstn(rstn), .go(go), .tx_busy(tx_busy),
        .dly(dly), .tx_ready(tx_ready), .tx_sent(tx_sent));
    always #20 sys_clk = ~sys_clk;
    // ====================
    // tasks
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(int n = 1);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        tick();
        sfr_wr = 0;
        tick();
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1;
        exp_q.push_back(e);
        tick();
        sfr_rd = 0;
        tick();
    endtask
    task automatic wait_busy(logic b);
        int i;
        for (i = 0; i < 40 && tx_busy !== b; i++) tick();
        chk("tx_busy", {7'h0, b}, {7'h0, tx_busy});
    endtask
    function automatic logic [7:0] st(logic [6:0] e);
        return {e[6], 1'b0, e[5], 1'b0, e[3:0]};
    endfunction
    // ====================
    // read result monitor and hang limit
    always @(posedge sys_clk) begin
        p1 <= sfr_rd;
        p2 <= p1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    always @(negedge sys_clk) if (p2) chk("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    // ====================
    // main sequence
    initial begin
        dly = 4'h2 + 4'($urandom(32'h11daa1a8) % 5);
        tick(12);
        rstn = 1;
        rd(CMP_ADDR_PAGE, CMP_PAGE_RESET);
        rd(CMP_ADDR_CTRL, CMP_CTRL_RESET);
        rd(CMP_ADDR_STATUS, CMP_STATUS_RESET);
        rd(8'hb0, 8'h00);
        for (int o = 0; o < 4; o++) begin
            v = {2'b00, 2'(o), 1'b1, 3'($urandom)};
            wr(CMP_ADDR_PAGE, v);
            chk("cur_object", {6'h0, v[5:4]}, {6'h0, cur_object});
            chk("cur_byte_index", {5'h0, v[2:0]}, {5'h0, cur_byte_index});
            rd(CMP_ADDR_PAGE, v);
        end
        for (int h = 0; h < 2; h++) begin
            wr(CMP_ADDR_PAGE, {4'h2, h[0], 3'h6});
            repeat (3) begin
                data_access = 1;
                tick();
                data_access = 0;
                tick();
            end
            chk("cur_byte_index", h ? 8'h06 : 8'h01, {5'h0, cur_byte_index});
        end
        wr(CMP_ADDR_PAGE, 8'h18);
        for (int r = 0; r < 4; r++) begin
            v = {2'(r), 2'($urandom), 4'($urandom)};
            wr(CMP_ADDR_CTRL, v);
            chk("obj_enable", r != 0 ? 8'h02 : 8'h00, {4'h0, obj_enable});
            chk("cur_ext_id", {7'h0, v[4]}, {7'h0, cur_ext_id});
            rd(CMP_ADDR_CTRL, v);
        end
        wr(CMP_ADDR_PAGE, 8'h38);
        wr(CMP_ADDR_CTRL, 8'h48);
        wr(CMP_ADDR_PAGE, 8'h18);
        wr(CMP_ADDR_CTRL, 8'h48);
        go = 1;
        for (int k = 1; k < 4; k += 2) begin
            wait_busy(1);
            chk("tx_object", 8'(k), {6'h0, tx_object});
            tx_in_arb_or_ack = (k == 1);
            tx_bit_mismatch = 1;
            tick();
            tx_bit_mismatch = 0;
            wait_busy(0);
        end
        go = 0;
        for (int k = 1; k < 4; k += 2) begin
            wr(CMP_ADDR_PAGE, {2'b00, 2'(k), 4'h8});
            rd(CMP_ADDR_STATUS, k == 1 ? 8'h40 : 8'h50);
        end
        wr(CMP_ADDR_PAGE, 8'h08);
        wr(CMP_ADDR_CTRL, 8'h80);
        wr(CMP_ADDR_PAGE, 8'h28);
        wr(CMP_ADDR_CTRL, 8'hc0);
        e1 = 7'($urandom) | 7'h22;
        e2 = 7'($urandom) | 7'h20;
        for (int j = 0; j < 2; j++) begin
            rx_hit = 4'h5;
            rx_event = cmp_event_t'(j ? e2 : e1);
            tick();
            rx_hit = 4'h0;
            rx_event = '0;
            tick();
        end
        chk("obj_enable", 8'h04, {4'h0, obj_enable});
        rd(CMP_ADDR_STATUS, st(e2));
        wr(CMP_ADDR_PAGE, 8'h08);
        rd(CMP_ADDR_STATUS, st(e1));
        // software clear of a status byte, then a clear that meets a set
        wr(CMP_ADDR_STATUS, 8'h00);
        rd(CMP_ADDR_STATUS, 8'h00);
        wr(CMP_ADDR_PAGE, 8'h28);
        sfr_addr = CMP_ADDR_STATUS;
        sfr_wdata = 8'h00;
        sfr_wr = 1;
        rx_hit = 4'h4;
        rx_event = cmp_event_t'(7'h22);
        tick();
        sfr_wr = 0;
        rx_hit = 4'h0;
        rx_event = '0;
        tick();
        rd(CMP_ADDR_STATUS, 8'h22);
        chk("obj_enable", 8'h04, {4'h0, obj_enable});
        tick(3);
        report_and_stop();
    end
endmodule
